/* rtl/dhi_pkg.sv */
// Shared constants and types of the display host interface, used by both ends.
// Assumes the host end runs on a 50 MHz system clock and the device end on the link clock.
//
// Function
// - Select line low command, high data.
// - 6800 mode: direction high reads, low writes.
// - 6800 mode: transfer completes on enable fall.
// - 8080 mode: write strobe is active low.
// - 8080 mode: read strobe low, device drives bus.
// - Parallel bus: host writes, device drives reads.
// - Reset input low holds device in reset.
// - Device reacts only while chip select low.
// - Straps 11/10/01/00 pick 6800/8080/3w/4w.
// - 3-wire serial: host ties select line low.
// - Serial: clock on line 0, data line 1.
// - Serial: input only, no read data returned.
package dhi_pkg;

	// ----------------------------------------
	// Modes and their strap codes
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		DHI_M6800 = 4'b0001,
		DHI_M8080 = 4'b0010,
		DHI_M3W = 4'b0100,
		DHI_M4W = 4'b1000
	} dhi_mode_e;

	localparam logic [1:0] DHI_STRAP_6800 = 2'h3;
	localparam logic [1:0] DHI_STRAP_8080 = 2'h2;
	localparam logic [1:0] DHI_STRAP_3W = 2'h1;
	localparam logic [1:0] DHI_STRAP_4W = 2'h0;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int DHI_DW = 8;
	localparam int DHI_SCLK_BIT = 0;
	localparam int DHI_SERIAL_IN_LINE_BIT = 1;
	localparam logic DHI_DC_CMD = 1'b0;
	localparam logic DHI_DC_DATA = 1'b1;
	localparam logic [7:0] DHI_BYTE_RST = 8'h00;

	// ----------------------------------------
	// Host timing
	// ----------------------------------------
	localparam int DHI_SYS_PERIOD_NS = 20;
	localparam int DHI_PHASE_NS = 320;
	localparam int DHI_PHASE_CYC = (DHI_PHASE_NS + DHI_SYS_PERIOD_NS - 1) / DHI_SYS_PERIOD_NS;

	function automatic dhi_mode_e dhi_decode(input logic [1:0] strap);
		case (strap)
			DHI_STRAP_6800: dhi_decode = DHI_M6800;
			DHI_STRAP_8080: dhi_decode = DHI_M8080;
			DHI_STRAP_3W: dhi_decode = DHI_M3W;
			default: dhi_decode = DHI_M4W;
		endcase
	endfunction

endpackage

/* rtl/dhi_if.sv */
// Pin carrier between the host end and the display device end.
// Assumes the eight data lines are pulled low when nobody drives them.
interface dhi_if;
	import dhi_pkg::*;

	logic [DHI_DW-1:0] host_d_o;
	logic host_d_oe;
	logic [DHI_DW-1:0] dev_d_o;
	logic dev_d_oe;
	logic [DHI_DW-1:0] parallel_bus_lines;
	logic dc;
	logic rw_wr_n;
	logic e_rd_n;
	logic cs_n;
	logic reset_in_n;
	logic bus_strap_hi;
	logic bus_strap_lo;

	// Wire level of the shared data lines; the host wins a clash.
	assign parallel_bus_lines = host_d_oe ? host_d_o : (dev_d_oe ? dev_d_o : DHI_BYTE_RST);

	modport host
	(
		output host_d_o, host_d_oe, dc, rw_wr_n, e_rd_n, cs_n, reset_in_n,
		output bus_strap_hi, bus_strap_lo,
		input parallel_bus_lines
	);

	modport device
	(
		output dev_d_o, dev_d_oe,
		input parallel_bus_lines, dc, rw_wr_n, e_rd_n, cs_n, reset_in_n,
		input bus_strap_hi, bus_strap_lo
	);
endinterface

/* rtl/dhi_device.sv */
// Display device end of the host interface: decodes the four bus types into a byte stream.
// Assumes every pin is asynchronous to clk_link and passes a two-stage synchroniser first.
module dhi_device
	import dhi_pkg::*;
(
	input wire logic clk_link, // Link clock.
	input wire logic srst, // Synchronous reset, active high.
	dhi_if.device link, // Pins toward the host.
	output logic rx_valid, // One-cycle pulse: byte received.
	output logic [DHI_DW-1:0] rx_byte, // Received byte.
	output logic rx_is_data, // High for data, low for command.
	output logic rd_take, // One-cycle pulse: read byte delivered.
	input wire logic [DHI_DW-1:0] rd_byte, // Byte returned on reads.
	output dhi_mode_e mode, // Bus type taken from the straps.
	output logic in_reset // High while the device is held in reset.
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [DHI_DW-1:0] d_m;
	logic [DHI_DW-1:0] d_s;
	logic [6:0] c_m;
	logic [6:0] c_s;
	logic e_q;
	logic rw_q;
	logic sclk_q;

	always_ff @(posedge clk_link)
	begin
		d_m <= link.parallel_bus_lines;
		d_s <= d_m;
		c_m <= {link.reset_in_n, link.bus_strap_hi, link.bus_strap_lo, link.cs_n,
			link.dc, link.rw_wr_n, link.e_rd_n};
		c_s <= c_m;
	end

	logic rst_n_s;
	logic [1:0] strap_s;
	logic cs_n_s;
	logic dc_s;
	logic rw_s;
	logic e_s;

	assign rst_n_s = c_s[6];
	assign strap_s = c_s[5:4];
	assign cs_n_s = c_s[3];
	assign dc_s = c_s[2];
	assign rw_s = c_s[1];
	assign e_s = c_s[0];

	// Internal reset: local reset or the host pulling the reset pin low.
	logic int_rst;
	assign int_rst = srst | ~rst_n_s;

	// Edge detectors look only at the second synchroniser stage.
	always_ff @(posedge clk_link)
	begin
		if (srst)
		begin
			e_q <= 1'b1;
			rw_q <= 1'b1;
			sclk_q <= 1'b0;
		end
		else
		begin
			e_q <= e_s;
			rw_q <= rw_s;
			sclk_q <= d_s[DHI_SCLK_BIT];
		end
	end

	// ----------------------------------------
	// Bus type and reset status
	// ----------------------------------------
	always_ff @(posedge clk_link)
	begin
		if (srst)
			mode <= DHI_M4W;
		else if (!rst_n_s)
			mode <= dhi_decode(strap_s);
	end

	always_ff @(posedge clk_link)
	begin
		if (srst)
			in_reset <= 1'b1;
		else
			in_reset <= ~rst_n_s;
	end

	// ----------------------------------------
	// Strobe events
	// ----------------------------------------
	logic sel;
	logic is_6800;
	logic is_8080;
	logic is_ser;
	logic e_fall;
	logic rd_rise;
	logic wr_rise;
	logic sclk_rise;

	assign sel = ~cs_n_s & ~int_rst;
	assign is_6800 = (mode == DHI_M6800);
	assign is_8080 = (mode == DHI_M8080);
	assign is_ser = (mode == DHI_M3W) | (mode == DHI_M4W);
	assign e_fall = e_q & ~e_s;
	assign rd_rise = ~e_q & e_s;
	assign wr_rise = ~rw_q & rw_s;
	assign sclk_rise = ~sclk_q & d_s[DHI_SCLK_BIT];

	logic par_wr;
	logic par_rd;

	// 6800: direction high reads, low writes, both completed by the enable fall.
	assign par_wr = sel & ((is_6800 & e_fall & ~rw_s) | (is_8080 & wr_rise));
	assign par_rd = sel & ((is_6800 & e_fall & rw_s) | (is_8080 & rd_rise));

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [DHI_DW-1:0] shreg;
	logic [2:0] bit_cnt;
	logic ser_done;

	assign ser_done = sel & is_ser & sclk_rise & (bit_cnt == 3'h7);

	always_ff @(posedge clk_link)
	begin
		if (srst || !sel || !is_ser)
		begin
			shreg <= DHI_BYTE_RST;
			bit_cnt <= 3'h0;
		end
		else if (sclk_rise)
		begin
			shreg <= {shreg[DHI_DW-2:0], d_s[DHI_SERIAL_IN_LINE_BIT]};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ----------------------------------------
	// Received byte
	// ----------------------------------------
	always_ff @(posedge clk_link)
	begin
		if (srst)
		begin
			rx_valid <= 1'b0;
			rx_byte <= DHI_BYTE_RST;
			rx_is_data <= DHI_DC_CMD;
		end
		else if (par_wr)
		begin
			rx_valid <= 1'b1;
			rx_byte <= d_s;
			rx_is_data <= dc_s;
		end
		else if (ser_done)
		begin
			rx_valid <= 1'b1;
			rx_byte <= {shreg[DHI_DW-2:0], d_s[DHI_SERIAL_IN_LINE_BIT]};
			rx_is_data <= (mode == DHI_M4W) ? dc_s : DHI_DC_CMD;
		end
		else
			rx_valid <= 1'b0;
	end

	// ----------------------------------------
	// Read drive
	// ----------------------------------------
	logic drive;

	// Serial modes never drive the bus back.
	assign drive = sel & ((is_6800 & rw_s & e_s) | (is_8080 & ~e_s));

	always_ff @(posedge clk_link)
	begin
		if (srst)
		begin
			link.dev_d_oe <= 1'b0;
			link.dev_d_o <= DHI_BYTE_RST;
			rd_take <= 1'b0;
		end
		else
		begin
			link.dev_d_oe <= drive;
			link.dev_d_o <= rd_byte;
			rd_take <= par_rd;
		end
	end

endmodule

/* rtl/dhi_host.sv */
// Host end of the display interface: turns byte requests into bus cycles.
// Assumes the strap code only changes while hold_reset is high.
//
// The placing of the registers and strobed register access were left to the implementer.
module dhi_host
	import dhi_pkg::*;
#(
	parameter int PHASE_CYC = DHI_PHASE_CYC
)
(
	input wire logic clk_sys, // System clock, 50 MHz.
	input wire logic srst, // Synchronous reset, active high.
	dhi_if.host link, // Pins toward the device.
	input wire logic [1:0] mode_sel, // Strap code to drive.
	input wire logic hold_reset, // High holds the device in reset.
	input wire logic cmd_valid, // Request present.
	output logic cmd_ready, // Ready to take a request.
	input wire logic cmd_read, // High reads, low writes.
	input wire logic cmd_is_data, // High data, low command.
	input wire logic [DHI_DW-1:0] cmd_byte, // Byte to write.
	output logic resp_valid, // One-cycle pulse: request finished.
	output logic [DHI_DW-1:0] resp_byte // Read byte, zero otherwise.
);

	typedef enum logic [5:0]
	{
		DHI_H_IDLE = 6'b000001,
		DHI_H_SETUP = 6'b000010,
		DHI_H_ACT = 6'b000100,
		DHI_H_HOLD = 6'b001000,
		DHI_H_SLO = 6'b010000,
		DHI_H_SHI = 6'b100000
	} dhi_hstate_e;

	dhi_hstate_e state;
	logic [15:0] cnt;
	logic [2:0] bit_cnt;
	logic rd;
	logic [DHI_DW-1:0] sh;
	logic [DHI_DW-1:0] d_m;
	logic [DHI_DW-1:0] d_s;
	dhi_mode_e hmode;
	logic tick;

	assign hmode = dhi_decode({link.bus_strap_hi, link.bus_strap_lo});
	assign tick = (cnt == 16'h0);

	// ----------------------------------------
	// Strap, reset and read-back synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		d_m <= link.parallel_bus_lines;
		d_s <= d_m;
		if (srst)
		begin
			link.bus_strap_hi <= 1'b0;
			link.bus_strap_lo <= 1'b0;
			link.reset_in_n <= 1'b0;
		end
		else
		begin
			{link.bus_strap_hi, link.bus_strap_lo} <= mode_sel;
			link.reset_in_n <= ~hold_reset;
		end
	end

	// ----------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst || hold_reset)
		begin
			state <= DHI_H_IDLE;
			cnt <= 16'h0;
			bit_cnt <= 3'h0;
			rd <= 1'b0;
			sh <= DHI_BYTE_RST;
			cmd_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_byte <= DHI_BYTE_RST;
			link.cs_n <= 1'b1;
			link.dc <= DHI_DC_CMD;
			link.rw_wr_n <= 1'b1;
			link.e_rd_n <= 1'b1;
			link.host_d_o <= DHI_BYTE_RST;
			link.host_d_oe <= 1'b0;
		end
		else
		begin
			resp_valid <= 1'b0;
			if (!tick)
				cnt <= cnt - 16'h1;
			case (state)
				DHI_H_IDLE:
				begin
					cmd_ready <= 1'b1;
					link.cs_n <= 1'b1;
					// Idle levels: 6800 enable low, 8080 strobes high, serial all low.
					link.e_rd_n <= (hmode == DHI_M8080);
					link.rw_wr_n <= (hmode != DHI_M3W) && (hmode != DHI_M4W);
					link.host_d_oe <= (hmode == DHI_M3W) || (hmode == DHI_M4W);
					link.host_d_o <= DHI_BYTE_RST;
					if (cmd_valid && cmd_ready)
					begin
						cmd_ready <= 1'b0;
						rd <= cmd_read && (hmode == DHI_M6800 || hmode == DHI_M8080);
						sh <= cmd_byte;
						bit_cnt <= 3'h0;
						link.cs_n <= 1'b0;
						link.dc <= (hmode == DHI_M3W) ? DHI_DC_CMD : cmd_is_data;
						if (hmode == DHI_M6800)
							link.rw_wr_n <= cmd_read;
						if (hmode == DHI_M6800 || hmode == DHI_M8080)
						begin
							link.host_d_oe <= !cmd_read;
							link.host_d_o <= cmd_byte;
						end
						cnt <= 16'(PHASE_CYC - 1);
						state <= DHI_H_SETUP;
					end
				end
				DHI_H_SETUP:
					if (tick)
					begin
						cnt <= 16'(PHASE_CYC - 1);
						if (hmode == DHI_M6800)
						begin
							link.e_rd_n <= 1'b1;
							state <= DHI_H_ACT;
						end
						else if (hmode == DHI_M8080)
						begin
							if (rd)
								link.e_rd_n <= 1'b0;
							else
								link.rw_wr_n <= 1'b0;
							state <= DHI_H_ACT;
						end
						else
						begin
							link.host_d_o[DHI_SERIAL_IN_LINE_BIT] <= sh[DHI_DW-1];
							state <= DHI_H_SLO;
						end
					end
				DHI_H_ACT:
					if (tick)
					begin
						cnt <= 16'(PHASE_CYC - 1);
						resp_byte <= rd ? d_s : DHI_BYTE_RST;
						// 6800 ends on the enable fall; 8080 on the strobe rise.
						link.e_rd_n <= (hmode == DHI_M8080);
						link.rw_wr_n <= (hmode == DHI_M8080) ? 1'b1 : rd;
						state <= DHI_H_HOLD;
					end
				DHI_H_SLO:
					if (tick)
					begin
						cnt <= 16'(PHASE_CYC - 1);
						link.host_d_o[DHI_SCLK_BIT] <= 1'b1;
						state <= DHI_H_SHI;
					end
				DHI_H_SHI:
					if (tick)
					begin
						cnt <= 16'(PHASE_CYC - 1);
						link.host_d_o[DHI_SCLK_BIT] <= 1'b0;
						bit_cnt <= bit_cnt + 3'h1;
						sh <= {sh[DHI_DW-2:0], 1'b0};
						if (bit_cnt == 3'h7)
						begin
							resp_byte <= DHI_BYTE_RST;
							state <= DHI_H_HOLD;
						end
						else
						begin
							link.host_d_o[DHI_SERIAL_IN_LINE_BIT] <= sh[DHI_DW-2];
							state <= DHI_H_SLO;
						end
					end
				DHI_H_HOLD:
					if (tick)
					begin
						link.cs_n <= 1'b1;
						link.host_d_oe <= (hmode == DHI_M3W) || (hmode == DHI_M4W);
						link.host_d_o <= DHI_BYTE_RST;
						resp_valid <= 1'b1;
						state <= DHI_H_IDLE;
					end
				default:
					state <= DHI_H_IDLE;
			endcase
		end
	end

endmodule

/* verification/dhi_properties.sv */
// Concurrent checks on the pins between the host end and the device end.
// Assumes every host-driven pin is a flop of clk_sys and srst resets the host end.
module dhi_properties
	import dhi_pkg::*;
(
	input wire logic clk_sys, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [DHI_DW-1:0] host_d_o, // Host data out.
	input wire logic host_d_oe, // Host drives the lines.
	input wire logic dev_d_oe, // Device drives the lines.
	input wire logic [DHI_DW-1:0] parallel_bus_lines, // Resolved data lines.
	input wire logic dc, // Data or command select.
	input wire logic rw_wr_n, // Direction or write strobe.
	input wire logic e_rd_n, // Enable or read strobe.
	input wire logic cs_n, // Chip select, active low.
	input wire logic bus_strap_hi, // Upper strap.
	input wire logic bus_strap_lo // Lower strap.
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic m6800;
	logic m8080;
	logic m3w;
	logic [3:0] cs_hi;

	assign m6800 = bus_strap_hi & bus_strap_lo;
	assign m8080 = bus_strap_hi & ~bus_strap_lo;
	assign m3w = ~bus_strap_hi & bus_strap_lo;

	// Counts how long chip select has stood high, saturating.
	always_ff @(posedge clk_sys)
	begin
		if (srst || !cs_n)
			cs_hi <= 4'h0;
		else if (cs_hi != 4'hf)
			cs_hi <= cs_hi + 4'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	bus_clash_a: assert property (!(host_d_oe && dev_d_oe))
		else $error("both ends drive the data lines");
	e_fall_hold_a: assert property ($fell(e_rd_n) && m6800 && !cs_n && !rw_wr_n
		|-> host_d_oe && $stable(host_d_o) && $stable(dc))
		else $error("write data moved at enable fall");
	e_rise_dir_a: assert property ($rose(e_rd_n) && m6800 && !cs_n
		|-> host_d_oe == !rw_wr_n)
		else $error("host drive does not follow direction");
	read_6800_a: assert property ($rose(e_rd_n) && m6800 && !cs_n && rw_wr_n
		|-> ##14 dev_d_oe)
		else $error("device did not drive a read");
	wr_strobe_a: assert property ($fell(rw_wr_n) && m8080 && !cs_n
		|-> host_d_oe && e_rd_n)
		else $error("write strobe without host data");
	rd_strobe_a: assert property ($fell(e_rd_n) && m8080 && !cs_n
		|-> (!host_d_oe && rw_wr_n) ##14 dev_d_oe)
		else $error("read strobe not answered by device");
	cs_idle_a: assert property (cs_hi == 4'hf |-> !dev_d_oe)
		else $error("device drives while not selected");
	serial_quiet_a: assert property (!bus_strap_hi && !cs_n
		|-> !dev_d_oe && !rw_wr_n && !e_rd_n && parallel_bus_lines[7:2] == 6'h00)
		else $error("serial mode lines not quiet");
	three_wire_dc_a: assert property (m3w && !cs_n |-> !dc)
		else $error("select line not low in three wire mode");
endmodule

/* verification/testbench.sv */
// Self-checking bench: host end and device end joined by the pin carrier.
// Assumes the design files of rtl are compiled first.
`define CHK(nm, ex, got) \
	begin \
		checked++; \
		if ((got) !== (ex)) \
		begin \
			mismatches++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end

module testbench;
	import dhi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys;
	logic clk_link;
	logic srst;
	logic [1:0] mode_sel;
	logic hold_reset;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_read;
	logic cmd_is_data;
	logic [DHI_DW-1:0] cmd_byte;
	logic resp_valid;
	logic [DHI_DW-1:0] resp_byte;
	logic rx_valid;
	logic [DHI_DW-1:0] rx_byte;
	logic rx_is_data;
	logic rd_take;
	logic [DHI_DW-1:0] rd_byte;
	dhi_mode_e mode;
	logic in_reset;
	logic [8:0] rx_exp;
	logic [8:0] exp_q[$];
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int n_take = 0;
	int take_exp = 0;
	int seed_val;
	logic [1:0] strap_tab[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
	dhi_mode_e mode_tab[4] = '{DHI_M6800, DHI_M8080, DHI_M3W, DHI_M4W};

	dhi_if link();

	dhi_host u_dhi_host (.clk_sys(clk_sys), .srst(srst), .link(link.host),
		.mode_sel(mode_sel), .hold_reset(hold_reset), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_is_data(cmd_is_data),
		.cmd_byte(cmd_byte), .resp_valid(resp_valid), .resp_byte(resp_byte));

	dhi_device u_dhi_device (.clk_link(clk_link), .srst(srst), .link(link.device),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
		.rd_take(rd_take), .rd_byte(rd_byte), .mode(mode), .in_reset(in_reset));

	dhi_properties u_dhi_properties (.clk_sys(clk_sys), .srst(srst),
		.host_d_o(link.host_d_o), .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe),
		.parallel_bus_lines(link.parallel_bus_lines), .dc(link.dc), .rw_wr_n(link.rw_wr_n),
		.e_rd_n(link.e_rd_n), .cs_n(link.cs_n), .bus_strap_hi(link.bus_strap_hi),
		.bus_strap_lo(link.bus_strap_lo));

	// ----------------------------------------
	// Clocks, monitor and hang guard
	// ----------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial
	begin
		clk_link = 1'b0;
		#7;
		forever #32 clk_link = ~clk_link;
	end

	// Every received byte must be the oldest one still owed by the model.
	always @(posedge clk_link)
	begin
		if (rx_valid === 1'b1)
		begin
			rx_exp = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff;
			`CHK("rx_byte", rx_exp, {rx_is_data, rx_byte})
		end
		if (rd_take === 1'b1)
			n_take++;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("Checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One host request; k indexes the mode tables.
	task automatic req(input logic rd, input logic isd, input logic [7:0] b,
		input logic [7:0] rb, input int k);
		int n;
		logic serial;
		logic [7:0] exp_r;
		n = 0;
		serial = (k >= 2);
		exp_r = (rd && !serial) ? rb : 8'h00;
		if (!rd || serial)
			exp_q.push_back({isd && k != 2, b});
		else
			take_exp++;
		rd_byte <= rb;
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_is_data <= isd;
		cmd_byte <= b;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 5000);
		cmd_valid <= 1'b0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (resp_valid !== 1'b1 && n < 5000);
		// A request that never finishes is a hang: count it and close the run.
		if (resp_valid !== 1'b1)
		begin
			mismatches++;
			wrap_up();
		end
		`CHK("resp_byte", exp_r, resp_byte)
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		srst = 1'b1;
		mode_sel = 2'h0;
		hold_reset = 1'b1;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_is_data = 1'b0;
		cmd_byte = 8'h00;
		rd_byte = 8'h00;
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		seed_val = $urandom(68313);
		for (int k = 0; k < 4; k++)
		begin
			hold_reset <= 1'b1;
			@(posedge clk_sys);
			mode_sel <= strap_tab[k];
			repeat (20) @(posedge clk_sys);
			`CHK("in_reset", 1'b1, in_reset)
			hold_reset <= 1'b0;
			repeat (20) @(posedge clk_sys);
			`CHK("in_reset", 1'b0, in_reset)
			`CHK("mode", mode_tab[k], mode)
			for (int i = 0; i < 8; i++)
				req(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom), k);
			repeat (20) @(posedge clk_sys);
			`CHK("rx_left", 0, exp_q.size())
			`CHK("rd_take", take_exp, n_take)
		end
		wrap_up();
	end
endmodule
